// ==== core/taoc_ctrl.sv ====
// alert output control: settings register, locks, shutdown staging and alert pin
// Operation
// RULE_01: output enable bit 3 clear keeps pin inactive; set lets it assert.
// RULE_02: either lock set ignores writes to enable, polarity and mode bits.
// RULE_03: critical-only bit 2 clear alerts on window or critical; set critical only.
// RULE_04: window lock keeps the critical-only bit unchanged.
// RULE_05: polarity bit 1 clear means active low, set active high.
// RULE_06: polarity change reaches the pin at once, no conversion needed.
// RULE_07: immediate polarity update also applies during shutdown.
// RULE_08: in shutdown the pin freezes, or de-asserts when sleep state is one.
// RULE_09: other settings and bus options apply after first conversion past shutdown.
// RULE_10: in shutdown with timeout off, or no data-line option, polarity waits.
// RULE_11: mode bit 0 clear is comparator, set is latched interrupt.
// RULE_12: alert clear write ends a latched alert; no effect in comparator; reads zero.
// RULE_13: asserted flag reads one while this block drives its alert.
// RULE_14: pin drives active level only when enabled and alert true.
`timescale 1ns/1ps
`include "taoc_cfg.svh"
module taoc_ctrl
  import taoc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic conv_clk,
  input wire logic alarm_window_evt,
  input wire logic crit_evt,
  output logic alert_pin_level,
  output logic alert_pin_oe,
  output logic irq
);
  taoc_pin_if pin_bus ();

  // register state: pend holds what software wrote, act what the logic uses
  logic [5:0] cfg_pend_ff; // {opts[2:0], en, crit, mode}
  logic [5:0] cfg_act_ff;
  logic pol_pend_ff;
  logic pol_act_ff;
  logic crit_lock_ff;
  logic win_lock_ff;
  logic shdn_ff;
  taoc_phase_t phase_ff;
  logic conv_s1_ff;
  logic conv_s2_ff;
  logic conv_s3_ff;
  logic cond_q_ff;
  logic latch_ff;
  logic alert_st_ff;
  logic asserted_q_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic irq_ff;
  logic [DATA_W-1:0] rdata_ff;

  // keep the old bit while locked, else take the written one
  function automatic logic keep_or_take(input logic old_v, input logic new_v, input logic lock);
    keep_or_take = lock ? old_v : new_v;
  endfunction : keep_or_take

  // address decode
  wire wr_set = reg_wr && (reg_addr == `TAOC_ADDR_SETTINGS);
  wire wr_ctrl = reg_wr && (reg_addr == `TAOC_ADDR_CTRL);
  wire wr_opts = reg_wr && (reg_addr == `TAOC_ADDR_OPTS);
  wire wr_istat = reg_wr && (reg_addr == `TAOC_ADDR_IRQ_STAT);
  wire wr_imask = reg_wr && (reg_addr == `TAOC_ADDR_IRQ_MASK);
  wire any_lock = crit_lock_ff | win_lock_ff;

  // lock-filtered next values of the written settings
  wire nxt_en_pend = wr_set ? keep_or_take(cfg_pend_ff[2], reg_wdata[`TAOC_BIT_EN], any_lock)
                            : cfg_pend_ff[2]; // RULE_02
  wire nxt_crit_pend = wr_set ? keep_or_take(cfg_pend_ff[1], reg_wdata[`TAOC_BIT_CRIT], win_lock_ff)
                              : cfg_pend_ff[1]; // RULE_04
  wire nxt_mode_pend = wr_set ? keep_or_take(cfg_pend_ff[0], reg_wdata[`TAOC_BIT_MODE], any_lock)
                              : cfg_pend_ff[0]; // RULE_02
  wire nxt_pol_pend = wr_set ? keep_or_take(pol_pend_ff, reg_wdata[`TAOC_BIT_POL], any_lock)
                             : pol_pend_ff; // RULE_02
  wire [2:0] nxt_opts_pend = wr_opts ? {reg_wdata[`TAOC_OPT_SDIO], reg_wdata[`TAOC_OPT_TMO_OFF],
                                        reg_wdata[`TAOC_OPT_SLEEP]} : cfg_pend_ff[5:3];
  wire [5:0] nxt_cfg_pend = {nxt_opts_pend, nxt_en_pend, nxt_crit_pend, nxt_mode_pend};

  // active copies: named views of the applied settings
  wire act_mode = cfg_act_ff[0];
  wire act_crit = cfg_act_ff[1];
  wire act_en = cfg_act_ff[2];
  wire act_sleep = cfg_act_ff[3];
  wire act_tmo_off = cfg_act_ff[4];
  wire act_sdio = cfg_act_ff[5];

  // conversion strobe from the converter clock; stages two and three together form the edge
  wire conv_pulse = conv_s2_ff & ~conv_s3_ff;
  wire frozen = (phase_ff != TAOC_RUN);
  wire wake_done = (phase_ff == TAOC_WAKE) && conv_pulse && !shdn_ff;

  // polarity is held only in sleep with these bus options
  wire hold_pol = (phase_ff == TAOC_SLEEP) && (act_tmo_off || !act_sdio); // RULE_10
  wire nxt_pol_act = hold_pol ? pol_act_ff : nxt_pol_pend; // RULE_06 RULE_07

  // staged settings: direct while running, else wait for first fresh conversion
  wire [5:0] nxt_cfg_act = (phase_ff == TAOC_RUN) ? nxt_cfg_pend
                         : (wake_done ? cfg_pend_ff : cfg_act_ff); // RULE_09

  // alert condition and latched interrupt
  wire cond = act_crit ? crit_evt : (alarm_window_evt | crit_evt); // RULE_03
  wire latch_set = cond & ~cond_q_ff & ~frozen;
  wire latch_clr = wr_set && reg_wdata[`TAOC_BIT_CLR] && act_mode; // RULE_12
  wire nxt_latch = !act_mode ? 1'b0 : (latch_set ? 1'b1 : (latch_clr ? 1'b0 : latch_ff)); // no stale latch
  wire run_alert = act_mode ? nxt_latch : cond; // RULE_11
  wire nxt_alert_st = !frozen ? run_alert
                    : (act_sleep ? 1'b0 : alert_st_ff); // RULE_08
  wire asserted = act_en & alert_st_ff; // RULE_01 RULE_14

  // interrupt status: events set, write-one clears, set wins
  wire [2:0] irq_evt;
  assign irq_evt[`TAOC_IRQ_ALERT] = asserted & ~asserted_q_ff;
  assign irq_evt[`TAOC_IRQ_CONV] = conv_pulse;
  assign irq_evt[`TAOC_IRQ_LOCKED] = wr_set & any_lock; // write partly refused
  wire [2:0] irq_w1c = wr_istat ? reg_wdata[2:0] : `TAOC_IRQ_RST;
  wire [2:0] nxt_irq_stat = irq_evt | (irq_stat_ff & ~irq_w1c);

  // read mux; alert clear always reads zero
  wire [DATA_W-1:0] rd_set = {{(DATA_W-6){1'b0}}, 1'b0, asserted, cfg_pend_ff[2],
                              cfg_pend_ff[1], pol_pend_ff, cfg_pend_ff[0]}; // RULE_13 RULE_12
  wire [DATA_W-1:0] rd_ctrl = {{(DATA_W-3){1'b0}}, shdn_ff, win_lock_ff, crit_lock_ff};
  wire [DATA_W-1:0] rd_opts = {{(DATA_W-3){1'b0}}, cfg_pend_ff[5:3]};
  wire [DATA_W-1:0] rd_istat = {{(DATA_W-3){1'b0}}, irq_stat_ff};
  wire [DATA_W-1:0] rd_imask = {{(DATA_W-3){1'b0}}, irq_mask_ff};
  wire [DATA_W-1:0] rd_val = (reg_addr == `TAOC_ADDR_SETTINGS) ? rd_set
                           : (reg_addr == `TAOC_ADDR_CTRL) ? rd_ctrl
                           : (reg_addr == `TAOC_ADDR_OPTS) ? rd_opts
                           : (reg_addr == `TAOC_ADDR_IRQ_STAT) ? rd_istat
                           : (reg_addr == `TAOC_ADDR_IRQ_MASK) ? rd_imask
                           : `TAOC_DATA_ZERO;

  // next shutdown phase
  taoc_phase_t nxt_phase;
  always_comb
  begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      TAOC_RUN: if (shdn_ff) nxt_phase = TAOC_SLEEP;
      TAOC_SLEEP: if (!shdn_ff) nxt_phase = TAOC_WAKE;
      TAOC_WAKE: if (shdn_ff) nxt_phase = TAOC_SLEEP;
                 else if (conv_pulse) nxt_phase = TAOC_RUN;
    endcase
  end

  // settings and polarity
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cfg_pend_ff <= `TAOC_CFG_RST;
      cfg_act_ff <= `TAOC_CFG_RST;
      pol_pend_ff <= `TAOC_BIT_RST;
      pol_act_ff <= `TAOC_BIT_RST;
    end
    else
    begin
      cfg_pend_ff <= nxt_cfg_pend;
      cfg_act_ff <= nxt_cfg_act;
      pol_pend_ff <= nxt_pol_pend;
      pol_act_ff <= nxt_pol_act;
    end
  end

  // locks are set-only and fall only at reset; shutdown is plain
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      crit_lock_ff <= `TAOC_BIT_RST;
      win_lock_ff <= `TAOC_BIT_RST;
      shdn_ff <= `TAOC_BIT_RST;
      phase_ff <= TAOC_RUN;
    end
    else
    begin
      crit_lock_ff <= crit_lock_ff | (wr_ctrl & reg_wdata[`TAOC_CTL_CRIT_LOCK]);
      win_lock_ff <= win_lock_ff | (wr_ctrl & reg_wdata[`TAOC_CTL_WIN_LOCK]);
      shdn_ff <= wr_ctrl ? reg_wdata[`TAOC_CTL_SHDN] : shdn_ff;
      phase_ff <= nxt_phase;
    end
  end

  // converter clock synchroniser and edge stage
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      conv_s1_ff <= 1'b0;
      conv_s2_ff <= 1'b0;
      conv_s3_ff <= 1'b0;
    end
    else
    begin
      conv_s1_ff <= conv_clk;
      conv_s2_ff <= conv_s1_ff;
      conv_s3_ff <= conv_s2_ff;
    end
  end

  // alert state
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cond_q_ff <= 1'b0;
      latch_ff <= 1'b0;
      alert_st_ff <= 1'b0;
      asserted_q_ff <= 1'b0;
    end
    else
    begin
      cond_q_ff <= cond;
      latch_ff <= nxt_latch;
      alert_st_ff <= nxt_alert_st;
      asserted_q_ff <= asserted;
    end
  end

  // interrupt and read data
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irq_stat_ff <= `TAOC_IRQ_RST;
      irq_mask_ff <= `TAOC_IRQ_RST;
      irq_ff <= 1'b0;
      rdata_ff <= `TAOC_DATA_ZERO;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= wr_imask ? reg_wdata[2:0] : irq_mask_ff;
      irq_ff <= |(nxt_irq_stat & (wr_imask ? reg_wdata[2:0] : irq_mask_ff));
      rdata_ff <= reg_rd ? rd_val : `TAOC_DATA_ZERO;
    end
  end

  // pin driver registers the level, so the pin trails the settings by one edge
  assign pin_bus.pol = pol_act_ff;
  assign pin_bus.asserted = asserted;
  taoc_pin u_pin (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin(pin_bus.drv)
  );

  assign alert_pin_level = pin_bus.pin_o;
  assign alert_pin_oe = pin_bus.pin_oe;
  assign irq = irq_ff;
  assign reg_rdata = rdata_ff;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence wake_conv_s;
    (phase_ff == TAOC_WAKE) && conv_pulse && !shdn_ff;
  endsequence
  sequence locked_write_s;
    wr_set && any_lock;
  endsequence

  lock_keeps_bits_a: assert property (locked_write_s |=> // RULE_02
    $stable(pol_pend_ff) && $stable(cfg_pend_ff[0]) && $stable(cfg_pend_ff[2]))
    else $error("locked settings bit changed");
  win_lock_crit_a: assert property (wr_set && win_lock_ff |=> $stable(cfg_pend_ff[1])) // RULE_04
    else $error("critical-only bit changed under window lock");
  pin_release_a: assert property (!asserted |=> !alert_pin_oe) // RULE_01
    else $error("pin driven while not asserted");
  pol_now_a: assert property (wr_set && !any_lock && phase_ff == TAOC_RUN |=> ##1 // RULE_06
    alert_pin_level == $past(reg_wdata[`TAOC_BIT_POL], 2))
    else $error("polarity did not reach the pin in two cycles");
  pol_hold_a: assert property (hold_pol |=> $stable(pol_act_ff)) // RULE_10
    else $error("polarity moved while held in sleep");
  sleep_deassert_a: assert property (frozen && act_sleep |=> !alert_st_ff) // RULE_08
    else $error("alert not de-asserted in sleep");
  sleep_freeze_a: assert property (frozen && !act_sleep |=> $stable(alert_st_ff)) // RULE_08
    else $error("alert changed while frozen");
  stage_hold_a: assert property (frozen && !wake_done |=> $stable(cfg_act_ff)) // RULE_09
    else $error("staged setting applied early");
  stage_apply_a: assert property (wake_conv_s |=> cfg_act_ff == $past(cfg_pend_ff) // RULE_09
    && phase_ff == TAOC_RUN)
    else $error("staged settings not applied at wake conversion");
  clear_latch_a: assert property (latch_clr && !latch_set |=> !latch_ff) // RULE_12
    else $error("alert clear did not end latch");
  flag_read_a: assert property (reg_rd && reg_addr == `TAOC_ADDR_SETTINGS |=> // RULE_13
    reg_rdata[`TAOC_BIT_FLAG] == $past(asserted) && !reg_rdata[`TAOC_BIT_CLR])
    else $error("flag readback mismatch");
  crit_only_a: assert property (!frozen && !act_mode && act_crit && !crit_evt |=> !alert_st_ff) // RULE_03
    else $error("window event alerted in critical-only mode");
endmodule : taoc_ctrl

// ==== include/taoc_cfg.svh ====
// register map, field positions and reset values of the alert output control block
`ifndef TAOC_CFG_SVH
`define TAOC_CFG_SVH
`define TAOC_ADDR_SETTINGS 8'h01
`define TAOC_ADDR_CTRL 8'h08
`define TAOC_ADDR_OPTS 8'h09
`define TAOC_ADDR_IRQ_STAT 8'h0a
`define TAOC_ADDR_IRQ_MASK 8'h0b
`define TAOC_BIT_MODE 0
`define TAOC_BIT_POL 1
`define TAOC_BIT_CRIT 2
`define TAOC_BIT_EN 3
`define TAOC_BIT_FLAG 4
`define TAOC_BIT_CLR 5
`define TAOC_CTL_CRIT_LOCK 0
`define TAOC_CTL_WIN_LOCK 1
`define TAOC_CTL_SHDN 2
`define TAOC_OPT_SLEEP 0
`define TAOC_OPT_TMO_OFF 1
`define TAOC_OPT_SDIO 2
`define TAOC_IRQ_ALERT 0
`define TAOC_IRQ_CONV 1
`define TAOC_IRQ_LOCKED 2
`define TAOC_CFG_RST 6'h00
`define TAOC_BIT_RST 1'h0
`define TAOC_IRQ_RST 3'h0
`define TAOC_DATA_ZERO 16'h0000
`endif

// ==== include/taoc_pkg.sv ====
// types shared by the alert output control modules
package taoc_pkg;
  // shutdown phases: running, asleep, awake but waiting for a fresh conversion
  typedef enum logic [1:0] {TAOC_RUN, TAOC_SLEEP, TAOC_WAKE} taoc_phase_t;
endpackage : taoc_pkg

// ==== include/taoc_pin_if.sv ====
// carrier between the alert control core and its pin driver
`timescale 1ns/1ps
interface taoc_pin_if;
  logic pol;
  logic asserted;
  logic pin_o;
  logic pin_oe;
  modport ctrl (output pol, output asserted, input pin_o, input pin_oe);
  modport drv (input pol, input asserted, output pin_o, output pin_oe);
endinterface : taoc_pin_if

// ==== core/taoc_pin.sv ====
// registered tri-state driver of the alert pin
`timescale 1ns/1ps
module taoc_pin
  import taoc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  taoc_pin_if.drv pin
);
  logic pin_o_ff;
  logic pin_oe_ff;

  // active level only while asserted; otherwise the pin is released
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pin_o_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end
    else
    begin
      pin_o_ff <= pin.pol; // RULE_05
      pin_oe_ff <= pin.asserted; // RULE_14
    end
  end

  assign pin.pin_o = pin_o_ff;
  assign pin.pin_oe = pin_oe_ff;
endmodule : taoc_pin

// ==== bench/taoc_far_end.sv ====
// far side model: converter clock source and pulled-up alert line
`timescale 1ns/1ps
module taoc_far_end (
  input wire logic conv_go,
  input wire logic alert_pin_level,
  input wire logic alert_pin_oe,
  output logic conv_clk,
  output logic alert_line
);
  // pull-up holds the line high whenever the block releases it
  assign alert_line = alert_pin_oe ? alert_pin_level : 1'b1;
  // 80 ns converter clock, only inside a burst; the odd offset keeps its edges off the 10 ns grid
  always
  begin
    conv_clk = 1'b0;
    wait (conv_go);
    #3;
    while (conv_go)
    begin
      #40;
      conv_clk = conv_go;
      #40;
      conv_clk = 1'b0;
    end
  end
endmodule : taoc_far_end

// ==== bench/taoc_ctrl_tb.sv ====
// self-checking bench of the alert output control block
`timescale 1ns/1ps
module taoc_ctrl_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic conv_clk;
  logic conv_go = 1'b0;
  logic win_evt = 1'b0;
  logic crit_evt = 1'b0;
  logic pin_o;
  logic pin_oe;
  logic irq;
  logic alert_line;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;

  taoc_ctrl i_taoc_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_clk(conv_clk),
    .alarm_window_evt(win_evt), .crit_evt(crit_evt), .alert_pin_level(pin_o), .alert_pin_oe(pin_oe), .irq(irq));
  taoc_far_end i_taoc_far_end (.conv_go(conv_go), .alert_pin_level(pin_o), .alert_pin_oe(pin_oe),
    .conv_clk(conv_clk), .alert_line(alert_line));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // an edge passes after each strobe so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdc(input string what, input logic [7:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
    @(posedge ref_clk);
  endtask : rdc

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : step

  // looks at {irq, oe, pin level, line level} once settled
  task automatic pin(input string what, input logic [3:0] exp);
    #1;
    chk(what, {12'h000, exp}, {12'h000, irq, pin_oe, pin_o, alert_line});
    @(posedge ref_clk);
  endtask : pin

  task automatic conv();
    conv_go <= 1'b1;
    step(12);
    conv_go <= 1'b0;
    step(3);
  endtask : conv

  task automatic t_reset();
    rdc("settings", 8'h01, 16'h0000);
    rdc("ctrl", 8'h08, 16'h0000);
    rdc("opts", 8'h09, 16'h0000);
    rdc("status", 8'h0a, 16'h0000);
    rdc("mask", 8'h0b, 16'h0000);
    rdc("unmapped", 8'h05, 16'h0000);
    crit_evt <= 1'b1;
    step(3);
    pin("disabled pin", 4'b0001);
  endtask : t_reset

  task automatic t_comparator();
    wr(8'h01, 16'h0008);
    step(1);
    pin("active low", 4'b0100);
    rdc("flag set", 8'h01, 16'h0018);
    wr(8'h01, 16'h000a);
    step(1);
    pin("active high", 4'b0111);
    crit_evt <= 1'b0;
    step(3);
    pin("comparator drop", 4'b0011);
    rdc("flag clear", 8'h01, 16'h000a);
  endtask : t_comparator

  task automatic t_crit_only();
    win_evt <= 1'b1;
    step(3);
    pin("window alert", 4'b0111);
    wr(8'h01, 16'h000e);
    step(2);
    pin("window ignored", 4'b0011);
    crit_evt <= 1'b1;
    step(3);
    pin("critical alert", 4'b0111);
    crit_evt <= 1'b0;
    win_evt <= 1'b0;
    wr(8'h01, 16'h000a);
    step(2);
  endtask : t_crit_only

  task automatic t_interrupt();
    wr(8'h0a, 16'h0007);
    wr(8'h0b, 16'h0001);
    wr(8'h01, 16'h000b);
    pin("no stale latch", 4'b0011);
    win_evt <= 1'b1;
    step(1);
    win_evt <= 1'b0;
    step(3);
    pin("latched", 4'b1111);
    rdc("alert status", 8'h0a, 16'h0001);
    wr(8'h01, 16'h002b);
    step(2);
    pin("cleared", 4'b1011);
    rdc("clear reads 0", 8'h01, 16'h000b);
    wr(8'h0a, 16'h0001);
    step(1);
    pin("irq cleared", 4'b0011);
    wr(8'h0b, 16'h0000);
    wr(8'h01, 16'h000a);
    crit_evt <= 1'b1;
    step(3);
    pin("masked", 4'b0111);
    wr(8'h01, 16'h002a);
    step(2);
    pin("clear in comparator", 4'b0111);
    crit_evt <= 1'b0;
    rdc("masked status", 8'h0a, 16'h0001);
  endtask : t_interrupt

  task automatic t_shutdown();
    wr(8'h09, 16'h0004);
    crit_evt <= 1'b1;
    step(3);
    pin("before sleep", 4'b0111);
    wr(8'h08, 16'h0004);
    crit_evt <= 1'b0;
    step(3);
    pin("frozen", 4'b0111);
    wr(8'h01, 16'h0008);
    step(1);
    pin("polarity in sleep", 4'b0100);
    wr(8'h01, 16'h0000);
    wr(8'h09, 16'h0005);
    step(2);
    pin("deferred", 4'b0100);
    wr(8'h08, 16'h0000);
    step(3);
    pin("awake frozen", 4'b0100);
    conv();
    pin("after conversion", 4'b0001);
  endtask : t_shutdown

  task automatic t_held_pol();
    wr(8'h09, 16'h0007);
    wr(8'h01, 16'h0008);
    crit_evt <= 1'b1;
    step(3);
    pin("asserted", 4'b0100);
    wr(8'h08, 16'h0004);
    step(3);
    pin("forced off", 4'b0001);
    wr(8'h01, 16'h000a);
    step(3);
    pin("polarity held", 4'b0001);
    wr(8'h08, 16'h0000);
    step(3);
    pin("polarity on exit", 4'b0011);
    conv();
    pin("running again", 4'b0111);
    crit_evt <= 1'b0;
    step(3);
  endtask : t_held_pol

  task automatic t_locks();
    wr(8'h0a, 16'h0007);
    wr(8'h08, 16'h0001);
    wr(8'h01, 16'h0005);
    rdc("critical lock", 8'h01, 16'h000e);
    rdc("locked status", 8'h0a, 16'h0004);
    wr(8'h08, 16'h0003);
    wr(8'h01, 16'h0001);
    rdc("window lock", 8'h01, 16'h000e);
    rdc("lock bits", 8'h08, 16'h0003);
  endtask : t_locks

  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // a hang is cut short well past the few hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    step(4);
    sys_rst <= 1'b0;
    step(1);
    t_reset();
    t_comparator();
    t_crit_only();
    t_interrupt();
    t_shutdown();
    t_held_pol();
    t_locks();
    results();
  end
endmodule : taoc_ctrl_tb
